// File: design/hdcu_pkg.sv
// Purpose: Shared constants for the device configuration upper bits block.
// Assumes: Byte-wide register port from the configuration engine.
// Notes: Bit positions and reset values of the configuration register.
package hdcu_pkg;
  localparam logic [7:0] HDCU_CFG_OFFSET = 8'h05;
  localparam int HDCU_STR_BIT = 7;
  localparam int HDCU_SER_BIT = 6;
  localparam int HDCU_LPB_BIT = 5;
  localparam int HDCU_RSVD_BIT = 4;
  localparam logic HDCU_STR_RST = 1'b0;
  localparam logic HDCU_SER_RST = 1'b0;
  localparam logic HDCU_LPB_RST = 1'b0;
  localparam logic HDCU_RSVD_VAL = 1'b1;
  localparam logic [3:0] HDCU_LOW_ZERO = 4'h0;
  // Reset and idle values of the registered outputs.
  localparam logic [7:0] HDCU_RDATA_RST = 8'h00;
  localparam logic [7:0] HDCU_MISS_DATA = 8'h00;
  localparam logic HDCU_ALLOW_RST = 1'h1;
  localparam logic HDCU_FORCE_RST = 1'h0;
  // Configuration source that may write the register.
  typedef enum logic [1:0] {
    HDCU_SRC_NONE = 2'b00,
    HDCU_SRC_I2C = 2'b01,
    HDCU_SRC_SMB = 2'b10
  } hdcu_src_e;
endpackage

// File: design/hdcu_lpm_if.sv
// Purpose: Carries link power state controls between the register and gate.
// Assumes: Single clock domain.
// Notes: The register end drives the block bit; the gate end answers.
`timescale 1ns/10ps
`default_nettype none
interface hdcu_lpm_if;
  logic block_cfg;
  logic forced;
  logic lpm_allowed;
  modport reg_end (output block_cfg, input forced, input lpm_allowed);
  modport gate_end (input block_cfg, output forced, output lpm_allowed);
endinterface
`default_nettype wire

// File: design/hdcu_lpm_gate.sv
// Purpose: Decides whether U1/U2 link power requests may be used.
// Assumes: Force and disconnect events are one-cycle pulses.
// Notes: The force latch survives changes of the block bit.
`timescale 1ns/10ps
`default_nettype none
module hdcu_lpm_gate (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Link events.
  input wire logic force_lpm_seen,
  input wire logic upstream_disconnect,
  // Register side.
  hdcu_lpm_if.gate_end lpm
);
  import hdcu_pkg::*;

  logic forced_q;
  logic forced_d;

  // A force exchange in the same cycle as a disconnect keeps the latch set.
  assign forced_d = force_lpm_seen | (forced_q & ~upstream_disconnect);
  assign lpm.forced = forced_q;
  assign lpm.lpm_allowed = ~lpm.block_cfg | forced_q;

  // Latch of the force exchange, cleared only by reset or disconnect.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      forced_q <= HDCU_FORCE_RST;
    end else begin
      forced_q <= forced_d;
    end
  end

  a_force_holds: assert property (@(posedge sys_clk) disable iff (rst)
    force_lpm_seen |=> forced_q)
    else $error("Force exchange not latched.");
  a_force_drops: assert property (@(posedge sys_clk) disable iff (rst)
    upstream_disconnect && !force_lpm_seen |=> !forced_q)
    else $error("Disconnect did not clear force latch.");
endmodule // hdcu_lpm_gate
`default_nettype wire

// File: design/hdcu_top.sv
// Purpose: Upper bits of the hub device configuration register.
// Assumes: Writes arrive as one-cycle strobes with source mode given.
// Notes: Bits 3 to 0 are outside this block and read as zero here.
// Notes: Reads are registered, so data follows the address by one cycle.
// Notes: The U1/U2 permission lags the block bit by one more cycle, so a
//        link layer sees a change two cycles after the write is taken.
// Notes: Writes in the idle source mode are dropped without any flag.
`timescale 1ns/10ps
`default_nettype none
module hdcu_top (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire hdcu_pkg::hdcu_src_e cfg_src,
  output logic [7:0] reg_rdata,
  // Link events.
  input wire logic force_lpm_seen,
  input wire logic upstream_disconnect,
  // Controls to the rest of the hub.
  output logic string_write_unlock,
  output logic serial_write_unlock,
  output logic link_low_power_block,
  output logic lpm_allowed
);
  import hdcu_pkg::*;

  // A write is taken only from a configuration source. The idle mode is
  // refused so that a stray strobe during bring-up cannot unlock strings.
  function automatic logic src_can_write(input hdcu_src_e src);
    return (src == HDCU_SRC_I2C) | (src == HDCU_SRC_SMB);
  endfunction

  // Read image of the upper nibble with the reserved bit forced to one.
  // The lower nibble belongs to other logic and reads as zero here.
  function automatic logic [7:0] cfg_image(input logic s,
                                           input logic n,
                                           input logic b);
    return {s, n, b, HDCU_RSVD_VAL, HDCU_LOW_ZERO};
  endfunction

  logic str_q;
  logic str_d;
  logic ser_q;
  logic ser_d;
  logic lpb_q;
  logic lpb_d;
  logic [7:0] rdata_q;
  logic allow_q;
  wire logic hit;
  wire logic wr_ok;
  wire logic [7:0] rdata_d;
  hdcu_lpm_if lpm ();

  // Only a configuration source may write; other modes leave it untouched.
  assign hit = (reg_addr == HDCU_CFG_OFFSET);
  assign wr_ok = hit & reg_wr & src_can_write(cfg_src);
  assign str_d = wr_ok ? reg_wdata[HDCU_STR_BIT] : str_q;
  assign ser_d = wr_ok ? reg_wdata[HDCU_SER_BIT] : ser_q;
  assign lpb_d = wr_ok ? reg_wdata[HDCU_LPB_BIT] : lpb_q;
  // Reads outside this offset return zero.
  assign rdata_d = hit ? cfg_image(str_q, ser_q, lpb_q) :
                   HDCU_MISS_DATA;
  assign lpm.block_cfg = lpb_q;

  hdcu_lpm_gate u_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .force_lpm_seen(force_lpm_seen),
    .upstream_disconnect(upstream_disconnect),
    .lpm(lpm)
  );

  // Register bits and registered outputs.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      str_q <= HDCU_STR_RST;
      ser_q <= HDCU_SER_RST;
      lpb_q <= HDCU_LPB_RST;
      rdata_q <= HDCU_RDATA_RST;
      allow_q <= HDCU_ALLOW_RST;
    end else begin
      str_q <= str_d;
      ser_q <= ser_d;
      lpb_q <= lpb_d;
      rdata_q <= rdata_d;
      allow_q <= lpm.lpm_allowed;
    end
  end

  assign reg_rdata = rdata_q;
  assign string_write_unlock = str_q;
  assign serial_write_unlock = ser_q;
  assign link_low_power_block = lpb_q;
  assign lpm_allowed = allow_q;

  a_rsvd_reads_one: assert property (@(posedge sys_clk) disable iff (rst)
    hit |=> reg_rdata[HDCU_RSVD_BIT])
    else $error("Reserved bit did not read one.");
  a_str_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ok |=> string_write_unlock == $past(reg_wdata[HDCU_STR_BIT]))
    else $error("String unlock not written.");
  a_ser_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ok |=> serial_write_unlock == $past(reg_wdata[HDCU_SER_BIT]))
    else $error("Serial unlock not written.");
  a_lpb_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ok |=> link_low_power_block == $past(reg_wdata[HDCU_LPB_BIT]))
    else $error("Block bit not written.");
  a_no_src_hold: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && cfg_src == HDCU_SRC_NONE |=> $stable(link_low_power_block))
    else $error("Write accepted without configuration source.");
  a_clear_allows: assert property (@(posedge sys_clk) disable iff (rst)
    !lpb_q |=> lpm_allowed)
    else $error("U1/U2 blocked while bit clear.");
  a_block_denies: assert property (@(posedge sys_clk) disable iff (rst)
    lpb_q && !lpm.forced |=> !lpm_allowed)
    else $error("U1/U2 allowed while blocked.");
  a_reset_locked: assert property (@(posedge sys_clk)
    rst |=> !string_write_unlock && !serial_write_unlock)
    else $error("Unlock bits set after reset.");

  c_smb_write: cover property (@(posedge sys_clk)
    wr_ok && cfg_src == HDCU_SRC_SMB);
  c_i2c_load: cover property (@(posedge sys_clk)
    wr_ok && cfg_src == HDCU_SRC_I2C);
  // Lower nibble of the read image.
  a_low_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
    hit |=> reg_rdata[3:0] == HDCU_LOW_ZERO)
    else $error("Lower nibble did not read zero.");
  // Other offsets must never leak the configuration bits.
  a_miss_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !hit |=> reg_rdata == HDCU_MISS_DATA)
    else $error("Unmapped offset returned data.");
  // The read image carries the bits as they stood at the address cycle.
  a_rdata_image: assert property (@(posedge sys_clk) disable iff (rst)
    hit |=> reg_rdata == cfg_image($past(str_q), $past(ser_q),
                                   $past(lpb_q)))
    else $error("Read image does not match the register bits.");
  // Without a taken write the unlock bits and the block bit keep their value.
  a_str_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_ok |=> $stable(string_write_unlock))
    else $error("String unlock changed without a write.");
  a_ser_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_ok |=> $stable(serial_write_unlock))
    else $error("Serial unlock changed without a write.");
  a_lpb_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_ok |=> $stable(link_low_power_block))
    else $error("Block bit changed without a write.");
  // An EEPROM load sets the block bit from the loaded byte.
  a_i2c_load: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ok && cfg_src == HDCU_SRC_I2C |=>
    link_low_power_block == $past(reg_wdata[HDCU_LPB_BIT]))
    else $error("EEPROM load did not set the block bit.");
  // A strobe from a refused source must leave the unlock bits alone.
  a_src_refused: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && hit && !src_can_write(cfg_src) |=>
    $stable(string_write_unlock) && $stable(serial_write_unlock))
    else $error("Unlock bit written from a refused source.");
  // A latched force exchange reopens U1/U2 whatever the block bit holds.
  a_force_allows: assert property (@(posedge sys_clk) disable iff (rst)
    lpm.forced |=> lpm_allowed)
    else $error("U1/U2 blocked after a force exchange.");
  // Reset must leave the link free to use U1/U2.
  a_reset_open: assert property (@(posedge sys_clk)
    rst |=> lpm_allowed && !link_low_power_block)
    else $error("U1/U2 not open after reset.");

  c_forced_block: cover property (@(posedge sys_clk)
    lpb_q && lpm.forced);
  c_force_cleared: cover property (@(posedge sys_clk)
    lpb_q && upstream_disconnect && lpm.forced);
  c_refused_write: cover property (@(posedge sys_clk)
    reg_wr && hit && cfg_src == HDCU_SRC_NONE);
endmodule // hdcu_top
`default_nettype wire

// File: test/hdcu_src_model.sv
// Purpose: Configuration source model, EEPROM loader or SMBus host.
// Assumes: Inputs change at the falling edge.
// Notes: Stale write data is inverted once the strobe drops.
`timescale 1ns/10ps
`default_nettype none
module hdcu_src_model
  import hdcu_pkg::*;
(
  // Clock.
  input wire logic sys_clk,
  // Register port.
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output var hdcu_src_e cfg_src
);
  // Idle values at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    cfg_src = HDCU_SRC_NONE;
  end
  // One-cycle write strobe from the given source.
  task automatic wr(input hdcu_src_e s, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = HDCU_CFG_OFFSET;
    reg_wr = 1'b1;
    reg_wdata = d;
    cfg_src = s;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // Read data is registered, so wait one edge.
  task automatic rd(input logic [7:0] ad);
    @(negedge sys_clk);
    reg_addr = ad;
    @(negedge sys_clk);
  endtask
endmodule // hdcu_src_model
`default_nettype wire

// File: test/hdcu_top_test.sv
// Purpose: Self-checking bench for the configuration upper bits.
// Assumes: Inputs change at the falling edge.
// Notes: Expected values come from the bit map.
`timescale 1ns/10ps
`default_nettype none
module hdcu_top_test;
  import hdcu_pkg::*;
  logic sys_clk, rst, fs, dc, wr, sw, nw, lb, la;
  logic [7:0] a, wd, rd;
  hdcu_src_e src;
  int miscompares = 0;
  int num_checks = 0;
  hdcu_top u_dut (.sys_clk, .rst, .reg_addr(a), .reg_wr(wr),
    .reg_wdata(wd), .cfg_src(src), .reg_rdata(rd),
    .force_lpm_seen(fs), .upstream_disconnect(dc),
    .string_write_unlock(sw), .serial_write_unlock(nw),
    .link_low_power_block(lb), .lpm_allowed(la));
  hdcu_src_model u_src (.sys_clk, .reg_addr(a), .reg_wr(wr),
    .reg_wdata(wd), .cfg_src(src));
  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Compare and count.
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rdc(logic [7:0] ad, logic [7:0] e);
    u_src.rd(ad);
    chk("rdata", rd, e);
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence; every wait is a fixed count from the timing.
  initial begin
    rst = 1'b1;
    fs = 1'b0;
    dc = 1'b0;
    step(6);
    rst = 1'b0;
    rdc(8'h05, 8'h10);
    chk("lpm", {7'h0, la}, 8'h01);
    $display("test reset done");
    u_src.wr(HDCU_SRC_SMB, 8'hff);
    chk("unl", {5'h0, sw, nw, lb}, 8'h07);
    step(1);
    chk("lpm", {7'h0, la}, 8'h00);
    u_src.wr(HDCU_SRC_NONE, 8'h00);
    rdc(8'h05, 8'hf0);
    rdc(8'h06, 8'h00);
    u_src.wr(HDCU_SRC_I2C, 8'h20);
    rdc(8'h05, 8'h30);
    $display("test writes done");
    fs = 1'b1;
    step(1);
    fs = 1'b0;
    step(1);
    chk("lpm", {7'h0, la}, 8'h01);
    u_src.wr(HDCU_SRC_SMB, 8'h20);
    step(1);
    chk("lpm", {7'h0, la}, 8'h01);
    dc = 1'b1;
    step(1);
    dc = 1'b0;
    step(1);
    chk("lpm", {7'h0, la}, 8'h00);
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    rdc(8'h05, 8'h10);
    u_src.wr(HDCU_SRC_SMB, 8'h20);
    step(1);
    chk("lpm", {7'h0, la}, 8'h00);
    $display("test force done");
    finish_test();
  end
endmodule // hdcu_top_test
`default_nettype wire
